// File: bench/flash_model.sv
`timescale 1ns/1ns
module flash_model #(
    parameter int ACC_CYCLES = 16
)
(
    input wire logic i_clock,
    input wire logic [2:0] i_select_n,
    input wire logic i_output_enable_n,
    input wire logic i_write_enable_n,
    input wire logic [15:0] i_addr,
    input wire logic [15:0] i_data,
    output logic [15:0] o_data
);
    logic [15:0] mem_reg = 16'h0000;
    logic [15:0] junk_reg = 16'hA5C3;
    logic [5:0] age_reg = 6'h00;
    logic we_reg = 1'b1;
    always @(posedge i_clock)
    begin
        // word taken on the rising strobe edge
        if (!we_reg && i_write_enable_n && i_select_n != 3'h7)
            mem_reg <= i_data;
        we_reg <= i_write_enable_n;
        junk_reg <= ~junk_reg;
        age_reg <= (i_output_enable_n || i_select_n == 3'h7) ? 6'h00 : age_reg + 6'h01;
    end
    // data is garbage until the access time has run out
    assign o_data = (age_reg >= ACC_CYCLES - 1 && !i_output_enable_n) ? mem_reg ^ i_addr : junk_reg;
endmodule

// File: bench/flash_port_sva.sv
`timescale 1ns/1ns
module flash_port_sva
    import flash_port_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_req,
    input wire logic i_write,
    input wire logic [flash_port_pkg::FULL_ADDR_BITS-1:0] i_addr,
    input wire logic [1:0] i_select,
    input wire logic i_ext_addr_en,
    input wire logic [flash_port_pkg::WAIT_BITS-1:0] i_select_setup_time,
    input wire logic [flash_port_pkg::WAIT_BITS-1:0] i_write_pulse_time,
    input wire logic [flash_port_pkg::WAIT_BITS-1:0] i_select_hold_time,
    input wire logic [flash_port_pkg::WAIT_BITS-1:0] i_read_access_time,
    input wire logic o_busy,
    input wire logic o_done,
    input wire logic o_flash_select_first_n,
    input wire logic o_flash_select_boot_n,
    input wire logic o_flash_select_third_n,
    input wire logic o_write_enable_n,
    input wire logic [flash_port_pkg::EXT_ADDR_BITS-1:0] o_gpio_addr,
    input wire logic o_gpio_addr_oe
);
    logic [5:0] s, p, h, a, c;
    logic w;
    wire logic sel = !(o_flash_select_first_n & o_flash_select_boot_n & o_flash_select_third_n);
    function automatic logic [4:0] lim(logic [4:0] x);
        return x == 5'h00 ? 5'h01 : (x > WAIT_MAX ? WAIT_MAX : x);
    endfunction
    // counts latched only while idle, so mid-access edits cannot leak in
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            c <= 6'h00;
            w <= 1'b0;
        end
        else
        begin
            c <= sel ? c + 6'h01 : 6'h00;
            if (!o_busy)
            begin
                {s, p, h, a} <= {1'b0, lim(i_select_setup_time), 1'b0, lim(i_write_pulse_time),
                                 1'b0, lim(i_select_hold_time), 1'b0, lim(i_read_access_time)};
                w <= i_write;
            end
        end
    end
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);
    a_setup_count: assert property ($fell(o_write_enable_n) |-> c == s) else $error("setup length wrong");
    a_pulse_count: assert property ($rose(o_write_enable_n) |-> c == s + p) else $error("pulse wrong");
    a_write_total: assert property (o_done && w |-> c == s + p + h) else $error("hold wrong");
    a_read_access: assert property (o_done && !w |-> c == a) else $error("access wrong");
    a_one_select: assert property ($countones({o_flash_select_first_n, o_flash_select_boot_n,
        o_flash_select_third_n}) >= 2) else $error("two selects low");
    a_boot_select: assert property (!o_busy && i_req && i_select == SEL_BOOT |=> !o_flash_select_boot_n)
        else $error("boot select missing");
    a_gpio_drive: assert property (!o_busy && i_req && i_select != 2'h3 && i_ext_addr_en |=> o_gpio_addr_oe
        && o_gpio_addr == $past(i_addr[25:24])) else $error("upper address wrong");
    a_we_in_select: assert property (!o_write_enable_n |-> sel) else $error("strobe outside select");
endmodule
bind flash_waitstate_port flash_port_sva flash_port_sva_inst (.*);

// File: bench/flash_waitstate_port_tb_top.sv
`timescale 1ns/1ns
module flash_waitstate_port_tb_top;
    import flash_port_pkg::*;
    logic i_clock = 0, i_rst = 1, i_req = 0, i_write = 0, i_ext_addr_en = 0;
    logic [25:0] i_addr = 0;
    logic [1:0] i_select = 0;
    logic [15:0] i_wdata = 0, i_flash_data, o_rdata, o_flash_data, last_word = 0;
    logic [4:0] i_select_setup_time = 2, i_write_pulse_time = 11, i_select_hold_time = 2, i_read_access_time = 19;
    logic o_busy, o_done, o_flash_select_first_n, o_flash_select_boot_n, o_flash_select_third_n;
    logic o_write_enable_n, o_output_enable_n, o_gpio_addr_oe, o_flash_data_oe;
    logic [23:0] o_flash_addr;
    logic [1:0] o_gpio_addr;
    int n_mismatch = 0, n_checks = 0;
    flash_waitstate_port flash_waitstate_port_inst (.*);
    flash_model flash_model_inst (.i_clock, .i_select_n({o_flash_select_third_n, o_flash_select_boot_n,
        o_flash_select_first_n}), .i_output_enable_n(o_output_enable_n), .i_write_enable_n(o_write_enable_n),
        .i_addr(o_flash_addr[15:0]), .i_data(o_flash_data), .o_data(i_flash_data));
    always #20 i_clock = ~i_clock;
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    function automatic logic [4:0] lim(logic [4:0] x);
        return x == 0 ? 5'h01 : (x > 19 ? 5'h13 : x);
    endfunction
    task automatic op(logic wr, logic [1:0] sel, logic [25:0] adr, logic [15:0] d, logic [4:0] s, p, h, a);
        int n, w;
        n = 0;
        w = 0;
        {i_write, i_select, i_addr, i_wdata, i_ext_addr_en, i_req} = {wr, sel, adr, d, adr[25], 1'b1};
        {i_select_setup_time, i_write_pulse_time, i_select_hold_time, i_read_access_time} = {s, p, h, a};
        do
        begin
            @(posedge i_clock);
            #2;
            n++;
            w += !o_write_enable_n;
            if (n == 1)
            begin
                {i_req, i_select_setup_time, i_write_pulse_time} = {1'b0, 10'h021};
                {i_select_hold_time, i_read_access_time} = {5'h01, 5'h01};
                chk("selects", 3'(~(3'h1 << sel)), {o_flash_select_third_n, o_flash_select_boot_n,
                    o_flash_select_first_n});
                chk("address", adr[23:0], o_flash_addr);
                chk("gpio", adr[25] ? {1'b1, adr[25:24]} : 3'h0, {o_gpio_addr_oe, o_gpio_addr});
                chk("enables", {wr, wr}, {o_flash_data_oe, o_output_enable_n});
                if (wr)
                    chk("write data", d, o_flash_data);
            end
        end
        while (o_done !== 1'b1 && n < 64);
        chk("done", 1'b1, o_done);
        chk("released", 7'h7C, {o_flash_select_third_n, o_flash_select_boot_n, o_flash_select_first_n,
            o_write_enable_n, o_output_enable_n, o_flash_data_oe, o_gpio_addr_oe});
        // n also counts the edge that takes the request
        if (wr)
        begin
            chk("write cycles", 1 + lim(s) + lim(p) + lim(h), n);
            chk("pulse cycles", lim(p), w);
            last_word = d;
        end
        else
        begin
            chk("read cycles", 1 + lim(a), n);
            chk("read data", last_word ^ adr[15:0], o_rdata);
        end
    endtask
    task automatic t_defaults;
        op(1, SEL_BOOT, 26'h2000ABC, 16'h5A3C, SETUP_RESET, PULSE_RESET, HOLD_RESET, ACCESS_RESET);
        op(0, SEL_BOOT, 26'h1000F0F, 0, 2, 11, 2, ACCESS_RESET);
        $display("default timing test done");
    endtask
    task automatic t_clamp;
        op(1, SEL_FIRST, 26'h3FFFFFF, 16'hC3A5, 5'h00, 5'h1F, 5'h14, 5'h13);
        op(0, SEL_THIRD, 26'h0FFFFFF, 0, 2, 11, 2, 5'h1F);
        $display("clamp test done");
    endtask
    task automatic t_derived;
        // slowest of the listed read delays (70, 100, 90 ns) sets the count
        op(0, SEL_FIRST, 26'h0000001, 0, 2, 11, 2, 5'((100 * 10 + 50 + 66) / 67));
        $display("derived count test done");
    endtask
    task automatic t_none;
        {i_select, i_req} = {2'h3, 1'b1};
        repeat (3) @(posedge i_clock);
        #2;
        chk("no device", 4'h7, {o_busy, o_flash_select_third_n, o_flash_select_boot_n, o_flash_select_first_n});
        i_req = 0;
        $display("unselected request done");
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        #200000;
        n_mismatch++;
        print_verdict;
    end
    initial
    begin
        repeat (10) @(posedge i_clock);
        #2;
        i_rst = 0;
        chk("reset", 5'h0F, {o_busy, o_flash_select_third_n, o_flash_select_boot_n, o_flash_select_first_n,
            o_write_enable_n});
        t_defaults;
        t_clamp;
        t_derived;
        t_none;
        print_verdict;
    end
endmodule

// File: hdl/flash_port_pkg.sv
package flash_port_pkg;
    localparam int REGION_ADDR_BITS = 24;
    localparam int EXT_ADDR_BITS = 2;
    localparam int FULL_ADDR_BITS = REGION_ADDR_BITS + EXT_ADDR_BITS;
    localparam int WAIT_BITS = 5;
    localparam logic [WAIT_BITS-1:0] WAIT_MAX = 5'h13;
    localparam logic [WAIT_BITS-1:0] SETUP_RESET = 5'h02;
    localparam logic [WAIT_BITS-1:0] PULSE_RESET = 5'h0B;
    localparam logic [WAIT_BITS-1:0] HOLD_RESET = 5'h02;
    localparam logic [WAIT_BITS-1:0] ACCESS_RESET = 5'h13;
    localparam logic [1:0] SEL_FIRST = 2'h0;
    localparam logic [1:0] SEL_BOOT = 2'h1;
    localparam logic [1:0] SEL_THIRD = 2'h2;
    typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_PULSE, ST_HOLD, ST_READ} phase_type;
endpackage

// File: hdl/flash_waitstate_port.sv
`timescale 1ns/1ns
module flash_waitstate_port
    import flash_port_pkg::*;
#(
    parameter int DATA_BITS = 16
)
(
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_req,
    input wire logic i_write,
    input wire logic [flash_port_pkg::FULL_ADDR_BITS-1:0] i_addr,
    input wire logic [1:0] i_select,
    input wire logic [DATA_BITS-1:0] i_wdata,
    input wire logic i_ext_addr_en,
    input wire logic [flash_port_pkg::WAIT_BITS-1:0] i_select_setup_time,
    input wire logic [flash_port_pkg::WAIT_BITS-1:0] i_write_pulse_time,
    input wire logic [flash_port_pkg::WAIT_BITS-1:0] i_select_hold_time,
    input wire logic [flash_port_pkg::WAIT_BITS-1:0] i_read_access_time,
    input wire logic [DATA_BITS-1:0] i_flash_data,
    output logic o_busy,
    output logic o_done,
    output logic [DATA_BITS-1:0] o_rdata,
    output logic o_flash_select_first_n,
    output logic o_flash_select_boot_n,
    output logic o_flash_select_third_n,
    output logic o_write_enable_n,
    output logic o_output_enable_n,
    output logic [flash_port_pkg::REGION_ADDR_BITS-1:0] o_flash_addr,
    output logic [flash_port_pkg::EXT_ADDR_BITS-1:0] o_gpio_addr,
    output logic o_gpio_addr_oe,
    output logic [DATA_BITS-1:0] o_flash_data,
    output logic o_flash_data_oe
);
    import flash_port_pkg::*;

    typedef struct packed {
        phase_type phase;
        logic [WAIT_BITS-1:0] count;
        logic [WAIT_BITS-1:0] setup;
        logic [WAIT_BITS-1:0] pulse;
        logic [WAIT_BITS-1:0] hold;
        logic [WAIT_BITS-1:0] access;
        logic busy;
        logic done;
        logic [DATA_BITS-1:0] rdata;
        logic [2:0] sel_n;
        logic we_n;
        logic oe_n;
        logic [REGION_ADDR_BITS-1:0] addr;
        logic [EXT_ADDR_BITS-1:0] gpio;
        logic gpio_oe;
        logic [DATA_BITS-1:0] wdata;
        logic wdata_oe;
    } state_type;

    state_type state_reg;
    state_type state_next;
    logic [WAIT_BITS-1:0] setup_lim;
    logic [WAIT_BITS-1:0] pulse_lim;
    logic [WAIT_BITS-1:0] hold_lim;
    logic [WAIT_BITS-1:0] access_lim;
    logic [WAIT_BITS-1:0] raw_count [0:3];
    logic [WAIT_BITS-1:0] lim_count [0:3];

    // one clamp per timing input; order is setup, pulse, hold, access
    assign raw_count[0] = i_select_setup_time;
    assign raw_count[1] = i_write_pulse_time;
    assign raw_count[2] = i_select_hold_time;
    assign raw_count[3] = i_read_access_time;

    generate
        for (genvar i = 0; i < 4; i++)
        begin : g_clamp
            wait_clamp wait_clamp_inst
            (
                .i_count(raw_count[i]),
                .o_count(lim_count[i])
            );
        end
    endgenerate

    assign setup_lim = lim_count[0];
    assign pulse_lim = lim_count[1];
    assign hold_lim = lim_count[2];
    assign access_lim = lim_count[3];

    // one-hot active-low select; unused code 3 selects nothing
    function automatic logic [2:0] select_decode(input logic [1:0] sel);
        if (sel == SEL_FIRST)
            select_decode = 3'h6;
        else if (sel == SEL_BOOT)
            select_decode = 3'h5;
        else if (sel == SEL_THIRD)
            select_decode = 3'h3;
        else
            select_decode = 3'h7;
    endfunction

    always_comb
    begin
        state_next = state_reg;
        state_next.done = 1'b0;
        case (state_reg.phase)
            ST_IDLE:
            begin
                state_next.setup = setup_lim;
                state_next.pulse = pulse_lim;
                state_next.hold = hold_lim;
                state_next.access = access_lim;
                if (i_req && select_decode(i_select) != 3'h7)
                begin
                    state_next.busy = 1'b1;
                    state_next.sel_n = select_decode(i_select);
                    state_next.addr = i_addr[REGION_ADDR_BITS-1:0];
                    state_next.gpio_oe = i_ext_addr_en;
                    state_next.gpio = i_ext_addr_en ? i_addr[FULL_ADDR_BITS-1:REGION_ADDR_BITS] : 2'h0;
                    state_next.count = 5'h01;
                    if (i_write)
                    begin
                        state_next.wdata = i_wdata;
                        state_next.wdata_oe = 1'b1;
                        state_next.phase = ST_SETUP;
                    end
                    else
                    begin
                        state_next.oe_n = 1'b0;
                        state_next.phase = ST_READ;
                    end
                end
            end
            ST_SETUP:
            begin
                if (state_reg.count >= state_reg.setup)
                begin
                    state_next.we_n = 1'b0;
                    state_next.count = 5'h01;
                    state_next.phase = ST_PULSE;
                end
                else
                    state_next.count = state_reg.count + 5'h01;
            end
            ST_PULSE:
            begin
                if (state_reg.count >= state_reg.pulse)
                begin
                    state_next.we_n = 1'b1;
                    state_next.count = 5'h01;
                    state_next.phase = ST_HOLD;
                end
                else
                    state_next.count = state_reg.count + 5'h01;
            end
            ST_HOLD:
            begin
                if (state_reg.count >= state_reg.hold)
                begin
                    state_next.sel_n = 3'h7;
                    state_next.wdata_oe = 1'b0;
                    state_next.gpio_oe = 1'b0;
                    state_next.busy = 1'b0;
                    state_next.done = 1'b1;
                    state_next.phase = ST_IDLE;
                end
                else
                    state_next.count = state_reg.count + 5'h01;
            end
            ST_READ:
            begin
                if (state_reg.count >= state_reg.access)
                begin
                    // sample only once the access time has run out
                    state_next.rdata = i_flash_data;
                    state_next.sel_n = 3'h7;
                    state_next.oe_n = 1'b1;
                    state_next.gpio_oe = 1'b0;
                    state_next.busy = 1'b0;
                    state_next.done = 1'b1;
                    state_next.phase = ST_IDLE;
                end
                else
                    state_next.count = state_reg.count + 5'h01;
            end
            default:
                state_next.phase = ST_IDLE;
        endcase
    end

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_reg.phase <= ST_IDLE;
            state_reg.count <= 5'h00;
            state_reg.setup <= SETUP_RESET;
            state_reg.pulse <= PULSE_RESET;
            state_reg.hold <= HOLD_RESET;
            state_reg.access <= ACCESS_RESET;
            state_reg.busy <= 1'b0;
            state_reg.done <= 1'b0;
            state_reg.rdata <= '0;
            state_reg.sel_n <= 3'h7;
            state_reg.we_n <= 1'b1;
            state_reg.oe_n <= 1'b1;
            state_reg.addr <= '0;
            state_reg.gpio <= 2'h0;
            state_reg.gpio_oe <= 1'b0;
            state_reg.wdata <= '0;
            state_reg.wdata_oe <= 1'b0;
        end
        else
            state_reg <= state_next;
    end

    assign o_busy = state_reg.busy;
    assign o_done = state_reg.done;
    assign o_rdata = state_reg.rdata;
    assign o_flash_select_first_n = state_reg.sel_n[0];
    assign o_flash_select_boot_n = state_reg.sel_n[1];
    assign o_flash_select_third_n = state_reg.sel_n[2];
    assign o_write_enable_n = state_reg.we_n;
    assign o_output_enable_n = state_reg.oe_n;
    assign o_flash_addr = state_reg.addr;
    assign o_gpio_addr = state_reg.gpio;
    assign o_gpio_addr_oe = state_reg.gpio_oe;
    assign o_flash_data = state_reg.wdata;
    assign o_flash_data_oe = state_reg.wdata_oe;
endmodule

// File: hdl/wait_clamp.sv
`timescale 1ns/1ns
module wait_clamp
    import flash_port_pkg::*;
(
    input wire logic [flash_port_pkg::WAIT_BITS-1:0] i_count,
    output logic [flash_port_pkg::WAIT_BITS-1:0] o_count
);
    always_comb
    begin
        // zero would give no wait at all; above max is unsupported
        if (i_count > WAIT_MAX)
            o_count = WAIT_MAX;
        else if (i_count == 5'h00)
            o_count = 5'h01;
        else
            o_count = i_count;
    end
endmodule
